//--- core/rbk_pkg.sv
/*
 Constants and types shared by the register bank and SPECIAL_FUNCTION_REGISTER core.
 Assumes one clock; all widths are byte wide unless noted.
*/
package rbk_pkg;
    // SPECIAL_FUNCTION_REGISTER addresses
    localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
    localparam logic [7:0] ADDR_EXT_LOW   = 8'h82;
    localparam logic [7:0] ADDR_EXT_HIGH  = 8'h83;
    localparam logic [7:0] ADDR_STATUS    = 8'hD0;
    localparam logic [7:0] ADDR_ANALOG    = 8'hDB;
    localparam logic [7:0] ADDR_WORK_A    = 8'hE0;
    localparam logic [7:0] ADDR_AUX       = 8'hF0;
    localparam int         NUM_PORTS      = 6;
    localparam logic [7:0] PORT_ADDR [NUM_PORTS] =
        '{8'h80, 8'h90, 8'hA0, 8'hB0, 8'hE8, 8'hF8};
    // Values after reset
    localparam logic [7:0] RESET_STACK_TOP = 8'h07;
    localparam logic [7:0] RESET_EXT       = 8'h00;
    localparam logic [7:0] RESET_STATUS    = 8'h00;
    localparam logic [7:0] RESET_WORK_A    = 8'h00;
    localparam logic [7:0] RESET_AUX       = 8'h00;
    localparam logic [7:0] RESET_PORT      = 8'hFF;
    localparam logic [7:0] RESET_RAM       = 8'h00;
    // Address space layout
    localparam int         SFR_AREA_BIT  = 7;
    localparam logic [7:0] BIT_RAM_BASE  = 8'h20;
    localparam logic [7:0] STACK_STEP    = 8'h01;
    // Status word field positions
    localparam int CARRY_POS     = 7;
    localparam int AUX_CARRY_POS = 6;
    localparam int USER_ZERO_POS = 5;
    localparam int BANK_HIGH_POS = 4;
    localparam int BANK_LOW_POS  = 3;
    localparam int EXCESS_POS    = 2;
    localparam int USER_ONE_POS  = 1;
    localparam int PARITY_POS    = 0;
    // Requests from the datapath
    typedef enum logic [3:0] {
        OP_NOP    = 4'h0, OP_DIR_RD = 4'h1, OP_DIR_WR = 4'h2,
        OP_IND_RD = 4'h3, OP_IND_WR = 4'h4, OP_REG_RD = 4'h5,
        OP_REG_WR = 4'h6, OP_BIT_RD = 4'h7, OP_BIT_WR = 4'h8,
        OP_PUSH   = 4'h9, OP_POP    = 4'hA, OP_EXT_PTR = 4'hB,
        OP_EXT_REG = 4'hC
    } rbk_op_t;
endpackage : rbk_pkg

//--- core/rbk_ram_if.sv
/*
 Ports of the internal data RAM: two read ports, one write port.
 Assumes reads are combinational and writes land on the clock edge.
*/
`timescale 1ns/1ps
interface rbk_ram_if;
    logic [7:0] ptr_addr;  // Index register location
    logic [7:0] ptr_data;  // Its contents
    logic [7:0] acc_addr;  // Operand location
    logic [7:0] acc_data;  // Operand contents
    logic       wr_en;     // Write strobe
    logic [7:0] wr_addr;   // Write location
    logic [7:0] wr_data;   // Write byte
    modport core  (output ptr_addr, acc_addr, wr_en, wr_addr, wr_data,
                   input ptr_data, acc_data);
    modport store (input ptr_addr, acc_addr, wr_en, wr_addr, wr_data,
                   output ptr_data, acc_data);
endinterface : rbk_ram_if

//--- core/rbk_ram.sv
/*
 Internal data RAM held in flip-flops, one entry per address.
 Assumes the core never writes while an SPECIAL_FUNCTION_REGISTER access is meant.
*/
`timescale 1ns/1ps
module rbk_ram #(
    parameter int DEPTH = 256
) (
    input wire logic clk,
    input wire logic rst_b,
    rbk_ram_if.store bus
);
    import rbk_pkg::*;
    logic [7:0] mem [DEPTH];  // Storage
    // One register per entry; stack may sit anywhere here
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                mem[i] <= RESET_RAM;
            end else if (bus.wr_en && bus.wr_addr == 8'(i)) begin
                mem[i] <= bus.wr_data;
            end
        end
    end
    assign bus.ptr_data = mem[bus.ptr_addr];
    assign bus.acc_data = mem[bus.acc_addr];
endmodule : rbk_ram

//--- core/rbk_status.sv
/*
 Status word: flags, bank select and hardware parity.
 Assumes flag updates come from the ALU on the same clock.
*/
`timescale 1ns/1ps
module rbk_status (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] work_a,     // Accumulator value
    input  wire logic       sfr_we,     // Byte write
    input  wire logic [7:0] sfr_wdata,
    input  wire logic [2:0] flag_we,    // Carry, aux carry, excess
    input  wire logic [2:0] flag_val,
    output logic      [7:0] status_word
);
    import rbk_pkg::*;
    logic [7:0] base_word;    // Software view before flag updates
    logic [7:0] next_status;  // Value for next edge
    assign base_word = sfr_we ? sfr_wdata : status_word;
    // ALU flags win over a software write in the same cycle
    always_comb begin
        next_status = base_word;
        if (flag_we[0]) begin
            next_status[CARRY_POS] = flag_val[0];
        end
        if (flag_we[1]) begin
            next_status[AUX_CARRY_POS] = flag_val[1];
        end
        if (flag_we[2]) begin
            next_status[EXCESS_POS] = flag_val[2];
        end
        // Parity is never writable; odd count of ones sets it
        next_status[PARITY_POS] = ^work_a;  // see [RQ11]
    end
    // Register; bank select resets to zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_word <= RESET_STATUS;  // see [RQ7]
        end else begin
            status_word <= next_status;   // see [RQ12]
        end
    end
endmodule : rbk_status

//--- core/rbk_core.sv
/*
 Register banks, stack, pointer pair and SPECIAL_FUNCTION_REGISTER core of the CPU.
 Assumes a datapath on the same clock issues one request a cycle.
*/
// Behaviour
// [RQ1] Stack pointer pre-increments on push, post-decrements pop
// [RQ2] Stack pointer resets to 07H
// [RQ3] Stack may use all internal RAM, unchecked
// [RQ4] Lowest 32 bytes form four register banks
// [RQ5] Status bits 3,4 choose active bank
// [RQ6] Bank codes map to bases 00H,08H,10H,18H
// [RQ7] Bank zero active after reset
// [RQ8] Opcode picks register; R0/R1 serve as pointers
// [RQ9] SFRs 80H-FFH only by direct addressing
// [RQ10] SFRs at multiples of eight are bit-addressable
// [RQ11] Parity flag tracks accumulator ones each cycle
// [RQ12] Status holds carry, aux carry, excess, user flags
// [RQ13] Pointer pair concatenates high and low bytes
// [RQ14] External address from pointer pair or register
// [RQ15] Aux register is multiply/divide operand, else scratch
// [RQ16] Six bit-addressable 8-bit port latches
// [RQ17] Analog input port reads live pin levels
// [RQ18] Upper RAM indirect only; lower both modes
// [RQ19] Bytes 20H-2FH hold 128 addressable bits
// [RQ20] Status word uses customary bit layout
`timescale 1ns/1ps
module rbk_core (
    // Clock and reset
    input  wire logic            CLK,
    input  wire logic            RST_B,
    // Request from the datapath
    input  wire logic            REQ_VALID,
    input  wire rbk_pkg::rbk_op_t REQ_OP,
    input  wire logic [7:0]      REQ_ADDR,
    input  wire logic [7:0]      REQ_WDATA,
    input  wire logic            REQ_BIT,
    // Answer to reads
    output logic                 RSP_VALID,
    output logic      [7:0]      RSP_DATA,
    output logic                 RSP_BIT,
    // ALU flag updates
    input  wire logic [2:0]      FLAG_WE,
    input  wire logic [2:0]      FLAG_VAL,
    // Multiply and divide results
    input  wire logic            MD_WE,
    input  wire logic [7:0]      MD_WORK_A,
    input  wire logic [7:0]      MD_AUX,
    // Analog input pins
    input  wire logic [7:0]      ANALOG_IN,
    // Register state to the datapath
    output logic      [7:0]      WORK_A,
    output logic      [7:0]      AUX,
    output logic      [7:0]      STATUS_WORD,
    output logic      [7:0]      STACK_TOP,
    output logic      [15:0]     EXT_POINTER,
    output logic      [15:0]     EXT_ADDR,
    output logic                 EXT_WIDE,
    output logic      [47:0]     PORT_LATCH
);
    import rbk_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Request decode
    logic is_dir_rd, is_dir_wr, is_ind_rd, is_ind_wr;
    logic is_reg_rd, is_reg_wr, is_bit_rd, is_bit_wr;
    logic is_push, is_pop, is_ext_ptr, is_ext_reg;
    logic is_dir, is_ind, is_reg, is_bit;  // Mode groups
    logic is_read, any_wr;                 // Answer and write flags
    assign is_dir_rd  = REQ_VALID && REQ_OP == OP_DIR_RD;
    assign is_dir_wr  = REQ_VALID && REQ_OP == OP_DIR_WR;
    assign is_ind_rd  = REQ_VALID && REQ_OP == OP_IND_RD;
    assign is_ind_wr  = REQ_VALID && REQ_OP == OP_IND_WR;
    assign is_reg_rd  = REQ_VALID && REQ_OP == OP_REG_RD;
    assign is_reg_wr  = REQ_VALID && REQ_OP == OP_REG_WR;
    assign is_bit_rd  = REQ_VALID && REQ_OP == OP_BIT_RD;
    assign is_bit_wr  = REQ_VALID && REQ_OP == OP_BIT_WR;
    assign is_push    = REQ_VALID && REQ_OP == OP_PUSH;
    assign is_pop     = REQ_VALID && REQ_OP == OP_POP;
    assign is_ext_ptr = REQ_VALID && REQ_OP == OP_EXT_PTR;
    assign is_ext_reg = REQ_VALID && REQ_OP == OP_EXT_REG;
    assign is_dir  = is_dir_rd || is_dir_wr;
    assign is_ind  = is_ind_rd || is_ind_wr;
    assign is_reg  = is_reg_rd || is_reg_wr;
    assign is_bit  = is_bit_rd || is_bit_wr;
    assign is_read = is_dir_rd || is_ind_rd || is_reg_rd || is_bit_rd || is_pop;
    assign any_wr  = is_dir_wr || is_ind_wr || is_reg_wr || is_bit_wr || is_push;

    ////////////////////////////////////////////////////////////////////
    // Registers held here
    logic [7:0] ext_low;        // Pointer pair, low byte
    logic [7:0] ext_high;       // Pointer pair, high byte
    logic [7:0] analog_meta;    // First sync stage, read only by second
    logic [7:0] analog_level;   // Synchronised pin levels
    logic [1:0] bank;           // Active register bank
    assign bank = STATUS_WORD[BANK_HIGH_POS:BANK_LOW_POS];  // see [RQ5] [RQ20]

    ////////////////////////////////////////////////////////////////////
    // Address formation
    rbk_ram_if ram ();
    logic [7:0] reg_addr;    // Register within active bank
    logic [7:0] bit_byte;    // Byte that holds an addressed bit
    logic [7:0] stack_next;  // Slot for the next push
    logic [7:0] stack_prev;  // Pointer after a pop
    logic [7:0] acc_addr;    // Operand location
    logic       acc_sfr;     // Operand lies in the SPECIAL_FUNCTION_REGISTER area
    // Bank number forms bits 4:3, so bases are 00H,08H,10H,18H
    assign reg_addr = {3'b000, bank, REQ_ADDR[2:0]};  // see [RQ4] [RQ6] [RQ8]
    // Index register R0 or R1 of the active bank
    assign ram.ptr_addr = {3'b000, bank, 2'b00, REQ_ADDR[0]};  // see [RQ8]
    // SPECIAL_FUNCTION_REGISTER bits map to their aligned byte; low bits to 20H-2FH
    assign bit_byte = REQ_ADDR[SFR_AREA_BIT] ? {REQ_ADDR[7:3], 3'b000}  // see [RQ10]
                    : (BIT_RAM_BASE | {4'h0, REQ_ADDR[6:3]});         // see [RQ19]
    // No bound check: wrap and overlap are the program's problem
    assign stack_next = STACK_TOP + STACK_STEP;  // see [RQ3]
    assign stack_prev = STACK_TOP - STACK_STEP;
    assign acc_addr = is_dir ? REQ_ADDR
                    : is_ind ? ram.ptr_data
                    : is_reg ? reg_addr
                    : is_bit ? bit_byte
                    : is_push ? stack_next
                    : STACK_TOP;
    // Only direct and bit modes reach SFRs; indirect goes to RAM
    assign acc_sfr = (is_dir || is_bit) && acc_addr[SFR_AREA_BIT];  // see [RQ9] [RQ18]
    assign ram.acc_addr = acc_addr;

    ////////////////////////////////////////////////////////////////////
    // SPECIAL_FUNCTION_REGISTER read decode
    logic [7:0] port_or [NUM_PORTS+1];  // Running OR of port hits
    logic [7:0] sfr_rd;                 // Selected SPECIAL_FUNCTION_REGISTER byte
    assign port_or[0] = 8'h00;
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_prd
        assign port_or[p+1] = port_or[p]
            | ((acc_addr == PORT_ADDR[p]) ? PORT_LATCH[8*p +: 8] : 8'h00);
    end
    // Unmapped SPECIAL_FUNCTION_REGISTER addresses read as zero
    assign sfr_rd = (acc_addr == ADDR_STACK_TOP) ? STACK_TOP
                  : (acc_addr == ADDR_EXT_LOW)   ? ext_low
                  : (acc_addr == ADDR_EXT_HIGH)  ? ext_high
                  : (acc_addr == ADDR_STATUS)    ? STATUS_WORD
                  : (acc_addr == ADDR_WORK_A)    ? WORK_A
                  : (acc_addr == ADDR_AUX)       ? AUX
                  : (acc_addr == ADDR_ANALOG)    ? analog_level  // see [RQ17]
                  : port_or[NUM_PORTS];

    ////////////////////////////////////////////////////////////////////
    // Byte and bit merge
    logic [7:0] byte_rd;     // Operand byte, SPECIAL_FUNCTION_REGISTER or RAM
    logic [7:0] bit_mask;    // One-hot addressed bit
    logic [7:0] bit_merged;  // Byte with the bit replaced
    logic [7:0] wr_byte;     // Byte to store
    logic       sfr_we;      // SPECIAL_FUNCTION_REGISTER write strobe
    assign byte_rd    = acc_sfr ? sfr_rd : ram.acc_data;
    assign bit_mask   = 8'h01 << REQ_ADDR[2:0];
    // Bit writes are read-modify-write of the whole byte
    assign bit_merged = REQ_BIT ? (byte_rd | bit_mask) : (byte_rd & ~bit_mask);
    assign wr_byte    = is_bit ? bit_merged : REQ_WDATA;
    assign sfr_we     = any_wr && acc_sfr;
    assign ram.wr_en   = any_wr && !acc_sfr;
    assign ram.wr_addr = acc_addr;
    assign ram.wr_data = wr_byte;
    // Per-register strobes; one decode each keeps the flop blocks short
    logic wr_stack_top, wr_ext_low, wr_ext_high;  // Pointer bytes
    logic wr_status, wr_work_a, wr_aux;           // Arithmetic registers
    assign wr_stack_top = sfr_we && acc_addr == ADDR_STACK_TOP;
    assign wr_ext_low   = sfr_we && acc_addr == ADDR_EXT_LOW;
    assign wr_ext_high  = sfr_we && acc_addr == ADDR_EXT_HIGH;
    assign wr_status    = sfr_we && acc_addr == ADDR_STATUS;
    assign wr_work_a    = sfr_we && acc_addr == ADDR_WORK_A;
    assign wr_aux       = sfr_we && acc_addr == ADDR_AUX;

    ////////////////////////////////////////////////////////////////////
    // Storage instances
    rbk_ram #(.DEPTH(256)) u_ram (
        .clk   (CLK),
        .rst_b (RST_B),
        .bus   (ram)
    );
    rbk_status u_status (
        .clk         (CLK),
        .rst_b       (RST_B),
        .work_a      (WORK_A),
        .sfr_we      (wr_status),
        .sfr_wdata   (wr_byte),
        .flag_we     (FLAG_WE),
        .flag_val    (FLAG_VAL),
        .status_word (STATUS_WORD)
    );

    ////////////////////////////////////////////////////////////////////
    // Stack pointer
    // Push stores at stack_next; pop reads at STACK_TOP then steps down
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            STACK_TOP <= RESET_STACK_TOP;  // see [RQ2]
        end else if (is_push) begin
            STACK_TOP <= stack_next;       // see [RQ1]
        end else if (is_pop) begin
            STACK_TOP <= stack_prev;       // see [RQ1]
        end else if (wr_stack_top) begin
            STACK_TOP <= wr_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pointer pair bytes
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ext_low  <= RESET_EXT;
            ext_high <= RESET_EXT;
        end else begin
            if (wr_ext_low) begin
                ext_low <= wr_byte;
            end
            if (wr_ext_high) begin
                ext_high <= wr_byte;
            end
        end
    end
    assign EXT_POINTER = {ext_high, ext_low};  // see [RQ13]

    ////////////////////////////////////////////////////////////////////
    // External address latch for external moves
    // Register form leaves the high byte zero; paging is elsewhere
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            EXT_ADDR <= 16'h0000;
            EXT_WIDE <= 1'b0;
        end else if (is_ext_ptr) begin
            EXT_ADDR <= {ext_high, ext_low};   // see [RQ14]
            EXT_WIDE <= 1'b1;
        end else if (is_ext_reg) begin
            EXT_ADDR <= {8'h00, ram.ptr_data}; // see [RQ14] [RQ8]
            EXT_WIDE <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Accumulator and aux register
    // Multiply/divide results land after any request write
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            WORK_A <= RESET_WORK_A;
        end else if (MD_WE) begin
            WORK_A <= MD_WORK_A;
        end else if (wr_work_a) begin
            WORK_A <= wr_byte;
        end
    end
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            AUX <= RESET_AUX;
        end else if (MD_WE) begin
            AUX <= MD_AUX;                  // see [RQ15]
        end else if (wr_aux) begin
            AUX <= wr_byte;                 // see [RQ15]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Port latches, bit and byte writable
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        always_ff @(posedge CLK or negedge RST_B) begin
            if (!RST_B) begin
                PORT_LATCH[8*p +: 8] <= RESET_PORT;
            end else if (sfr_we && acc_addr == PORT_ADDR[p]) begin
                PORT_LATCH[8*p +: 8] <= wr_byte;  // see [RQ16]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Analog pins: no latch, two-stage synchroniser only
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            analog_meta  <= 8'h00;
            analog_level <= 8'h00;
        end else begin
            analog_meta  <= ANALOG_IN;
            analog_level <= analog_meta;  // see [RQ17]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read answer, one cycle after the request
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RSP_VALID <= 1'b0;
            RSP_DATA  <= 8'h00;
            RSP_BIT   <= 1'b0;
        end else begin
            RSP_VALID <= is_read;
            if (is_read) begin
                RSP_DATA <= byte_rd;
                RSP_BIT  <= byte_rd[REQ_ADDR[2:0]];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!RST_B);
    logic after_rst;  // Low only in the first cycle after release
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            after_rst <= 1'b0;
        end else begin
            after_rst <= 1'b1;
        end
    end
    a_sp_reset_value: assert property (!after_rst |-> STACK_TOP == 8'h07) // see [RQ2]
        else $error("stack pointer not 07H after reset");
    a_bank_reset_zero: assert property (!after_rst |-> STATUS_WORD[4:3] == 2'b00) // see [RQ7]
        else $error("bank not zero after reset");
    a_sp_push_step: assert property (is_push |=> STACK_TOP == $past(STACK_TOP) + 8'h01) // see [RQ1]
        else $error("push did not pre-increment");
    a_sp_pop_step: assert property (is_pop |=> STACK_TOP == $past(STACK_TOP) - 8'h01) // see [RQ1]
        else $error("pop did not post-decrement");
    a_push_pop_data: assert property (is_push ##1 is_pop |=> RSP_DATA == $past(REQ_WDATA, 2)) // see [RQ3]
        else $error("popped byte differs from pushed byte");
    a_bank_reg_addr: assert property (is_reg |-> acc_addr == {3'b000, STATUS_WORD[4:3], REQ_ADDR[2:0]}) // see [RQ6]
        else $error("register address off active bank");
    a_ind_not_sfr: assert property ((is_ind && ram.ptr_data[7]) |-> !acc_sfr) // see [RQ9]
        else $error("indirect access reached SPECIAL_FUNCTION_REGISTER");
    a_parity_track: assert property (after_rst |-> STATUS_WORD[0] == ^$past(WORK_A)) // see [RQ11]
        else $error("parity flag wrong");
    a_aux_md_load: assert property (MD_WE |=> AUX == $past(MD_AUX)) // see [RQ15]
        else $error("aux register missed multiply result");
    a_ext_wide_addr: assert property (is_ext_ptr |=> EXT_ADDR == $past(EXT_POINTER) && EXT_WIDE) // see [RQ13]
        else $error("wide external address wrong");
    a_analog_live: assert property ((is_dir_rd && REQ_ADDR == 8'hDB) |=> RSP_DATA == $past(ANALOG_IN, 3)) // see [RQ17]
        else $error("analog port not live");
    a_bit_ram_byte: assert property ((is_bit && !REQ_ADDR[7]) |-> acc_addr == 8'h20 + {4'h0, REQ_ADDR[6:3]}) // see [RQ19]
        else $error("bit byte outside 20H-2FH");
    a_ext_narrow_addr: assert property (is_ext_reg |=> EXT_ADDR[15:8] == 8'h00 && !EXT_WIDE) // see [RQ14]
        else $error("narrow external address wrong");
    c_push_pop: cover property (is_push ##1 is_pop);
    c_bank_three: cover property (is_reg_rd && STATUS_WORD[4:3] == 2'b11);
    c_sfr_bit_wr: cover property (is_bit_wr && REQ_ADDR[7]);
    c_ext_reg: cover property (is_ext_reg);
    c_analog_read: cover property (is_dir_rd && REQ_ADDR == ADDR_ANALOG);
endmodule : rbk_core

//--- tb/rbk_dp_model.sv
/*
 Datapath model: issues register requests and ALU/multiply updates.
 Assumes the core takes a request on the rising edge of clk.
*/
`timescale 1ns/1ps
module rbk_dp_model
    import rbk_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Request side
    output logic       req_valid,
    output rbk_op_t    req_op,
    output logic [7:0] req_addr,
    output logic [7:0] req_wdata,
    output logic       req_bit,
    // ALU side
    output logic [2:0] flag_we,
    output logic [2:0] flag_val,
    output logic       md_we,
    output logic [7:0] md_work_a,
    output logic [7:0] md_aux
);
    // Idle values at time zero
    initial begin
        {req_valid, req_bit, md_we, flag_we, flag_val} = '0;
        {req_addr, req_wdata, md_work_a, md_aux} = '0;
        req_op = OP_NOP;
    end
    ////////////////////////////////////////////////////////////////
    // One-cycle request, launched and dropped on falling edges
    task automatic req(input rbk_op_t op, input logic [7:0] a, d, input logic b);
        @(negedge clk);
        req_valid <= 1'b1;
        req_op    <= op;
        {req_addr, req_wdata, req_bit} <= {a, d, b};
        @(negedge clk);
        req_valid <= 1'b0;
    endtask : req
    // Two requests on consecutive edges; valid stays high between them
    task automatic req_pair(input rbk_op_t op1, op2, input logic [7:0] d1);
        @(negedge clk);
        req_valid <= 1'b1;
        req_op    <= op1;
        req_wdata <= d1;
        @(negedge clk);
        req_op    <= op2;
        @(negedge clk);
        req_valid <= 1'b0;
    endtask : req_pair
    // One-cycle flag and multiply result pulse
    task automatic alu(input logic [2:0] we, v, input logic [7:0] wa, ax);
        @(negedge clk);
        {flag_we, flag_val, md_we, md_work_a, md_aux} <= {we, v, 1'b1, wa, ax};
        @(negedge clk);
        {flag_we, md_we} <= '0;
    endtask : alu
endmodule : rbk_dp_model

//--- tb/rbk_core_tb.sv
/*
 Self-checking bench of the register bank and SPECIAL_FUNCTION_REGISTER core.
 Assumes the datapath model drives every request input.
*/
`timescale 1ns/1ps
module rbk_core_tb;
    import rbk_pkg::*;
    logic        CLK = 0, RST_B = 0, RSP_VALID, RSP_BIT, EXT_WIDE, REQ_VALID, REQ_BIT, MD_WE;
    rbk_op_t     REQ_OP;
    logic [7:0]  REQ_ADDR, REQ_WDATA, MD_WORK_A, MD_AUX, RSP_DATA, WORK_A, AUX;
    logic [7:0]  ANALOG_IN = 8'hA5, STATUS_WORD, STACK_TOP;
    logic [2:0]  FLAG_WE, FLAG_VAL;
    logic [15:0] EXT_POINTER, EXT_ADDR;
    logic [47:0] PORT_LATCH;
    int          mismatches = 0, num_checks = 0;
    always #25 CLK = ~CLK;
    rbk_core u_dut (.CLK(CLK), .RST_B(RST_B), .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP),
        .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_BIT(REQ_BIT), .RSP_VALID(RSP_VALID),
        .RSP_DATA(RSP_DATA), .RSP_BIT(RSP_BIT), .FLAG_WE(FLAG_WE), .FLAG_VAL(FLAG_VAL),
        .MD_WE(MD_WE), .MD_WORK_A(MD_WORK_A), .MD_AUX(MD_AUX), .ANALOG_IN(ANALOG_IN),
        .WORK_A(WORK_A), .AUX(AUX), .STATUS_WORD(STATUS_WORD), .STACK_TOP(STACK_TOP),
        .EXT_POINTER(EXT_POINTER), .EXT_ADDR(EXT_ADDR), .EXT_WIDE(EXT_WIDE),
        .PORT_LATCH(PORT_LATCH));
    rbk_dp_model u_dp (.clk(CLK), .req_valid(REQ_VALID), .req_op(REQ_OP), .req_addr(REQ_ADDR),
        .req_wdata(REQ_WDATA), .req_bit(REQ_BIT), .flag_we(FLAG_WE), .flag_val(FLAG_VAL),
        .md_we(MD_WE), .md_work_a(MD_WORK_A), .md_aux(MD_AUX));
    ////////////////////////////////////////////////////////////////
    // Compare one result, widened to 16 bits
    task automatic chk(input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Read with answer exactly one cycle later
    task automatic rd(input rbk_op_t op, input logic [7:0] a, exp);
        u_dp.req(op, a, 8'h00, 1'b0);
        chk(16'(RSP_VALID), 16'h0001);
        chk(16'(RSP_DATA), 16'(exp));
    endtask : rd
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(negedge CLK);
        RST_B = 1'b1;
        chk(16'(STACK_TOP), 16'h0007);
        chk(16'(STATUS_WORD[4:3]), 16'h0000);
        chk(PORT_LATCH[15:0], 16'hFFFF);
        $display("test reset done");
        u_dp.req(OP_PUSH, 8'h00, 8'h5A, 1'b0);
        chk(16'(STACK_TOP), 16'h0008);
        rd(OP_DIR_RD, 8'h08, 8'h5A);
        rd(OP_POP, 8'h00, 8'h5A);
        chk(16'(STACK_TOP), 16'h0007);
        // Push and pop on consecutive edges: the pop sees the fresh byte
        u_dp.req_pair(OP_PUSH, OP_POP, 8'hC3);
        chk(16'(RSP_DATA), 16'h00C3);
        chk(16'(STACK_TOP), 16'h0007);
        $display("test stack done");
        // Same register number lands in a different bank each pass
        for (int b = 0; b < 4; b++) begin
            u_dp.req(OP_DIR_WR, ADDR_STATUS, 8'(b << 3), 1'b0);
            u_dp.req(OP_REG_WR, 8'h02, 8'(8'h40 + b), 1'b0);
            rd(OP_DIR_RD, 8'(b * 8 + 2), 8'(8'h40 + b));
        end
        u_dp.req(OP_DIR_WR, ADDR_STATUS, 8'h00, 1'b0);
        $display("test banks done");
        u_dp.req(OP_REG_WR, 8'h00, 8'h90, 1'b0);
        u_dp.req(OP_IND_WR, 8'h00, 8'h77, 1'b0);
        rd(OP_IND_RD, 8'h00, 8'h77);
        rd(OP_DIR_RD, 8'h90, 8'hFF);
        u_dp.req(OP_REG_WR, 8'h01, 8'h30, 1'b0);
        u_dp.req(OP_EXT_REG, 8'h01, 8'h00, 1'b0);
        chk(EXT_ADDR, 16'h0030);
        chk(16'(EXT_WIDE), 16'h0000);
        u_dp.req(OP_DIR_WR, ADDR_EXT_HIGH, 8'h12, 1'b0);
        u_dp.req(OP_DIR_WR, ADDR_EXT_LOW, 8'h34, 1'b0);
        u_dp.req(OP_EXT_PTR, 8'h00, 8'h00, 1'b0);
        chk(EXT_POINTER, 16'h1234);
        chk(EXT_ADDR, 16'h1234);
        chk(16'(EXT_WIDE), 16'h0001);
        $display("test pointers done");
        // Parity lags the accumulator by one cycle
        u_dp.req(OP_DIR_WR, ADDR_WORK_A, 8'h07, 1'b0);
        @(negedge CLK);
        chk(16'(STATUS_WORD[0]), 16'h0001);
        u_dp.req(OP_DIR_WR, ADDR_AUX, 8'h5C, 1'b0);
        rd(OP_DIR_RD, ADDR_AUX, 8'h5C);
        u_dp.alu(3'b001, 3'b001, 8'h03, 8'hC4);
        chk({WORK_A, AUX}, 16'h03C4);
        chk(16'(STATUS_WORD[7]), 16'h0001);
        @(negedge CLK);
        chk(16'(STATUS_WORD[0]), 16'h0000);
        $display("test flags done");
        rd(OP_DIR_RD, ADDR_ANALOG, 8'hA5);
        // A new pin level needs two edges through the synchroniser
        ANALOG_IN = 8'h3C;
        repeat (2) @(negedge CLK);
        rd(OP_DIR_RD, ADDR_ANALOG, 8'h3C);
        u_dp.req(OP_BIT_WR, 8'h03, 8'h00, 1'b1);
        rd(OP_DIR_RD, BIT_RAM_BASE, 8'h08);
        rd(OP_BIT_RD, 8'h03, 8'h08);
        chk(16'(RSP_BIT), 16'h0001);
        u_dp.req(OP_BIT_WR, 8'h80, 8'h00, 1'b0);
        chk(PORT_LATCH[15:0], 16'hFFFE);
        $display("test bits done");
        end_sim();
    end
endmodule : rbk_core_tb
